// ---- hw/gpo_top.sv ----
// Pin output function selection and interrupt aggregation with an AHB-Lite register slave
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module gpo_top
  import gpo_pkg::*;
#(
  parameter int DIVIDER_WIDTH = DIV_W
) (
  input wire logic sys_clk,                         // System clock, 100 MHz
  input wire logic rst,                             // Asynchronous reset, active high
  input wire logic hsel,                            // AHB slave select
  input wire logic [31:0] haddr,                    // AHB address
  input wire logic [1:0] htrans,                    // AHB transfer type
  input wire logic hwrite,                          // AHB write
  input wire logic [2:0] hsize,                     // AHB size, word only
  input wire logic [31:0] hwdata,                   // AHB write data
  input wire logic hready,                          // AHB bus ready
  output logic [31:0] hrdata,                       // AHB read data
  output logic hreadyout,                           // AHB slave ready
  output logic hresp,                               // AHB response, always OKAY
  input wire logic [NUM_PINS-1:0] gp_pin_in,        // Pins 3..5 input level
  output logic [NUM_PINS-1:0] gp_pin_out,           // Pins 3..5 output level
  output logic [NUM_PINS-1:0] gp_pin_oe,            // Pins 3..5 output enable
  output logic [NUM_PINS-1:0] pin_pull_up,          // Pins 3..5 pull-up enable
  output logic [NUM_PINS-1:0] pin_pull_down,        // Pins 3..5 pull-down enable
  input wire logic gp_input_7,                      // Input-only pin 7
  input wire logic gp_input_8,                      // Input-only pin 8
  input wire logic lock_status,                     // PLL lock, high when locked
  input wire logic temp_ok_status,                  // Temperature, low when overheated
  input wire logic mic_detect_status,               // Mic current detect
  input wire logic mic_short_status,                // Mic short detect
  output logic audio_if_tristate,                   // Audio interface tristate control
  output logic irq_out                              // Combined interrupt after inversion
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] enable_reg;
  logic [15:0] polarity_reg;
  logic [15:0] pin_select_reg;
  logic [15:0] clock_pad_reg;
  logic [NUM_SRC-1:0] latch_reg;
  logic [NUM_SRC-1:0] latch_next;
  logic [NUM_SRC-1:0] src_raw;
  logic [NUM_SRC-1:0] src_adj;
  logic [NUM_SRC-1:0] clear_mask;
  logic irq_flag;
  logic irq_pin;
  logic [DIVIDER_WIDTH-1:0] div_cnt_reg;
  logic divided_clock_out_reg;
  logic [NUM_PINS-1:0] pin_drive_reg;
  logic [NUM_PINS-1:0] pin_oe_reg;
  logic [NUM_PINS-1:0] pin_seen;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  gpo_phase_t phase_reg;
  logic [5:0] idx_reg;
  logic [31:0] hrdata_reg;
  logic take;
  logic wr_commit;
  logic [31:0] rd_value;

  assign take = hsel && htrans[1] && hready;
  assign wr_commit = (phase_reg == PH_WRITE);
  // Reads take one wait state so the data always follows a write that just ended
  assign hreadyout = (phase_reg != PH_READ_WAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= PH_IDLE;
      idx_reg <= 6'h00;
    end else begin
      case (phase_reg)
        PH_READ_WAIT: begin
          phase_reg <= PH_READ_DONE;
        end
        default: begin
          if (take) begin
            idx_reg <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
            phase_reg <= hwrite ? PH_WRITE : PH_READ_WAIT;
          end else begin
            phase_reg <= PH_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    case (idx_reg)
      IDX_STATUS: rd_value = {19'h0, irq_flag, latch_reg};
      IDX_INTERRUPT_ENABLE_CONTROL: rd_value = {16'h0, enable_reg};
      IDX_SOURCE_POLARITY_CONTROL: rd_value = {16'h0, polarity_reg};
      IDX_PIN_FUNCTION_SELECT: rd_value = {16'h0, pin_select_reg};
      IDX_CLOCK_PAD_CONTROL: rd_value = {16'h0, clock_pad_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (phase_reg == PH_READ_WAIT) begin
      hrdata_reg <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable_reg <= ENABLE_RESET;
    end else if (wr_commit && idx_reg == IDX_INTERRUPT_ENABLE_CONTROL) begin
      enable_reg <= hwdata[15:0] & ENABLE_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      polarity_reg <= POLARITY_RESET;
    end else if (wr_commit && idx_reg == IDX_SOURCE_POLARITY_CONTROL) begin
      polarity_reg <= hwdata[15:0] & POLARITY_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_select_reg <= PIN_SELECT_RESET;
    end else if (wr_commit && idx_reg == IDX_PIN_FUNCTION_SELECT) begin
      pin_select_reg <= {4'h0, hwdata[11:0]};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clock_pad_reg <= CLOCK_PAD_RESET;
    end else if (wr_commit && idx_reg == IDX_CLOCK_PAD_CONTROL) begin
      clock_pad_reg <= hwdata[15:0] & CLOCK_PAD_WR_MASK;
    end
  end

  // Pad controls; software must keep pulls off on driven pins
  assign audio_if_tristate = clock_pad_reg[BIT_TRISTATE];
  assign pin_pull_up = clock_pad_reg[FLD_PULL_UP_LSB +: NUM_PINS];
  assign pin_pull_down = clock_pad_reg[FLD_PULL_DOWN_LSB +: NUM_PINS];

  // ----------------------------------------------------------------
  // Clock output divider
  // ----------------------------------------------------------------
  // Half period is divider+1 system clocks; stopping holds the level low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt_reg <= '0;
      divided_clock_out_reg <= 1'b0;
    end else if (!clock_pad_reg[BIT_CLK_ENABLE]) begin
      div_cnt_reg <= '0;
      divided_clock_out_reg <= 1'b0;
    end else if (div_cnt_reg >= DIVIDER_WIDTH'(clock_pad_reg[FLD_DIV_LSB +: DIV_W])) begin
      div_cnt_reg <= '0;
      divided_clock_out_reg <= ~divided_clock_out_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + DIVIDER_WIDTH'(1);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sources and latches
  // ----------------------------------------------------------------
  // A pin used as an output feeds no input, to avoid loops
  assign pin_seen = gp_pin_in & ~pin_oe_reg;

  always_comb begin
    src_raw = '0;
    src_raw[BIT_PIN3] = pin_seen[0];
    src_raw[BIT_PIN4] = pin_seen[1];
    src_raw[BIT_PIN5] = pin_seen[2];
    src_raw[BIT_IN7] = gp_input_7;
    src_raw[BIT_IN8] = gp_input_8;
    src_raw[BIT_LOCK] = lock_status;
    src_raw[BIT_MIC_DET] = mic_detect_status;
    src_raw[BIT_MIC_SHORT] = mic_short_status;
    src_raw[BIT_TEMP] = temp_ok_status;
  end

  // Polarity acts on the latch path only
  assign src_adj = (src_raw ^ polarity_reg[NUM_SRC-1:0]) & SRC_USED_MASK;

  assign clear_mask = (wr_commit && idx_reg == IDX_STATUS) ? hwdata[NUM_SRC-1:0] : '0;

  // Set beats clear, so a source still asserted relatches at once
  assign latch_next = (latch_reg & ~clear_mask) | src_adj;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_reg <= '0;
    end else begin
      latch_reg <= latch_next;
    end
  end

  assign irq_flag = |(latch_reg & enable_reg[NUM_SRC-1:0]);
  assign irq_pin = irq_flag ^ polarity_reg[BIT_IRQ_INVERT];
  assign irq_out = irq_pin;

  // ----------------------------------------------------------------
  // Pin function multiplexer
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      gpo_sel_t sel;
      logic drive;
      logic oe;

      assign sel = gpo_sel_t'(pin_select_reg[gi*SEL_W +: SEL_W]);

      always_comb begin
        oe = 1'b1;
        case (sel)
          SEL_CLOCK_OUT: drive = divided_clock_out_reg;
          SEL_LOGIC_LOW: drive = 1'b0;
          SEL_LOGIC_HIGH: drive = 1'b1;
          SEL_LOCK: drive = lock_status;
          SEL_TEMP: drive = temp_ok_status;
          SEL_IRQ: drive = irq_pin;
          SEL_MIC_DET: drive = mic_detect_status;
          SEL_MIC_SHORT: drive = mic_short_status;
          default: begin
            drive = 1'b0;
            oe = 1'b0;
          end
        endcase
      end

      // The audio tristate control also releases the pins
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pin_drive_reg[gi] <= 1'b0;
          pin_oe_reg[gi] <= 1'b0;
        end else begin
          pin_drive_reg[gi] <= drive;
          pin_oe_reg[gi] <= oe && !clock_pad_reg[BIT_TRISTATE];
        end
      end
    end
  endgenerate

  assign gp_pin_out = pin_drive_reg;
  assign gp_pin_oe = pin_oe_reg;

endmodule

`default_nettype wire

// ---- hw/gpo_pkg.sv ----
// Package: register map, field layout, select codes and reset values for the pin function block
package gpo_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_STATUS = 6'h12;
  localparam logic [5:0] IDX_INTERRUPT_ENABLE_CONTROL = 6'h16;
  localparam logic [5:0] IDX_SOURCE_POLARITY_CONTROL = 6'h17;
  localparam logic [5:0] IDX_PIN_FUNCTION_SELECT = 6'h18;
  localparam logic [5:0] IDX_CLOCK_PAD_CONTROL = 6'h19;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 7;

  // ----------------------------------------------------------------
  // Status and source bit positions
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 12;
  localparam int BIT_PIN3 = 2;
  localparam int BIT_PIN4 = 3;
  localparam int BIT_PIN5 = 4;
  localparam int BIT_IN7 = 6;
  localparam int BIT_IN8 = 7;
  localparam int BIT_LOCK = 8;
  localparam int BIT_MIC_DET = 9;
  localparam int BIT_MIC_SHORT = 10;
  localparam int BIT_TEMP = 11;
  localparam int BIT_IRQ = 12;
  // Bits 0, 1 and 5 of the pin status field are reserved
  localparam logic [NUM_SRC-1:0] SRC_USED_MASK = 12'hfdc;

  // ----------------------------------------------------------------
  // Polarity and enable register fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_IRQ_INVERT = 12;
  localparam int BIT_READBACK_3W = 15;
  localparam int BIT_READBACK_MODE = 14;
  localparam logic [15:0] POLARITY_RESET = 16'h0800;
  localparam logic [15:0] ENABLE_RESET = 16'h8000;
  localparam logic [15:0] ENABLE_WR_MASK = 16'hcfdc;
  localparam logic [15:0] POLARITY_WR_MASK = 16'h1fdc;

  // ----------------------------------------------------------------
  // Pin function select register: 4 bits per pin, pin 3 lowest
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 3;
  localparam int SEL_W = 4;
  localparam logic [15:0] PIN_SELECT_RESET = 16'h0000;

  typedef enum logic [3:0] {
    SEL_INPUT = 4'h0,
    SEL_CLOCK_OUT = 4'h1,
    SEL_LOGIC_LOW = 4'h2,
    SEL_LOGIC_HIGH = 4'h3,
    SEL_LOCK = 4'h4,
    SEL_TEMP = 4'h5,
    SEL_READBACK = 4'h6,
    SEL_IRQ = 4'h7,
    SEL_MIC_DET = 4'h8,
    SEL_MIC_SHORT = 4'h9
  } gpo_sel_t;

  // ----------------------------------------------------------------
  // Clock and pad control register fields
  // ----------------------------------------------------------------
  localparam int DIV_W = 4;
  localparam int FLD_DIV_LSB = 0;
  localparam int BIT_CLK_ENABLE = 4;
  localparam int BIT_TRISTATE = 5;
  localparam int FLD_PULL_UP_LSB = 8;
  localparam int FLD_PULL_DOWN_LSB = 12;
  localparam logic [15:0] CLOCK_PAD_RESET = 16'h0000;
  localparam logic [15:0] CLOCK_PAD_WR_MASK = 16'h773f;

  // ----------------------------------------------------------------
  // Bus phase states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_WRITE = 4'b0010,
    PH_READ_WAIT = 4'b0100,
    PH_READ_DONE = 4'b1000
  } gpo_phase_t;

endpackage

// ---- tb/gpo_top_asserts.sv ----
// Checker: bus timing, pad control and flag hold at the top ports
`timescale 1ns/10ps
`default_nettype none
module gpo_top_asserts
  import gpo_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [NUM_PINS-1:0] gp_pin_oe, // Pin enables
  input wire logic [NUM_PINS-1:0] pin_pull_up, // Pull-ups
  input wire logic [NUM_PINS-1:0] pin_pull_down, // Pull-downs
  input wire logic audio_if_tristate, // Tristate
  input wire logic irq_out // Flag
);
  // ------------------------------------------------------------
  // Transfer tracking
  // ------------------------------------------------------------
  logic take;
  logic rd_dp;
  logic wr_dp;
  logic inv_reg;
  logic [5:0] wr_idx;
  assign take = hsel && htrans[1] && hready;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_dp <= 1'b0;
      wr_dp <= 1'b0;
      wr_idx <= 6'h00;
    end else if (hready) begin
      rd_dp <= take && !hwrite;
      wr_dp <= take && hwrite;
      wr_idx <= haddr[7:2];
    end
  end
  // Own copy of the invert bit, so the active flag level is known
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      inv_reg <= 1'b0;
    else if (wr_dp && hready && wr_idx == IDX_SOURCE_POLARITY_CONTROL)
      inv_reg <= hwdata[BIT_IRQ_INVERT];
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_wait;
    !hreadyout;
  endsequence
  sequence s_ready;
    hreadyout;
  endsequence
  chk_read_wait: assert property (take && !hwrite |=> s_wait ##1 s_ready)
    else $error("read answer timing wrong");
  chk_write_nowait: assert property (take && hwrite |=> s_ready)
    else $error("write data phase stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_reset_clean: assert property ($fell(rst) |-> hreadyout && gp_pin_oe == '0 && !irq_out)
    else $error("outputs not idle after reset");
  chk_rdata_stable: assert property ($changed(hrdata) |-> $past(rd_dp))
    else $error("read data moved outside a read");
  chk_pads_write: assert property ($changed({pin_pull_up, pin_pull_down, audio_if_tristate}) |-> $past(wr_dp))
    else $error("pad control moved without a write");
  chk_oe_tristate: assert property (audio_if_tristate && $past(audio_if_tristate) |-> gp_pin_oe == '0)
    else $error("pin driven while tristated");
  chk_irq_sticky: assert property ($past(irq_out) != $past(inv_reg) && !$past(wr_dp) |-> irq_out != inv_reg)
    else $error("flag dropped without a write");
endmodule
bind gpo_top gpo_top_asserts chk (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .hreadyout, .hresp, .gp_pin_oe, .pin_pull_up, .pin_pull_down,
  .audio_if_tristate, .irq_out);
`default_nettype wire

// ---- tb/gpo_host_model.sv ----
// Far side model: button drivers, pulls and the resolved pin wire level
`timescale 1ns/10ps
`default_nettype none
module gpo_host_model
  import gpo_pkg::*;
(
  input wire logic [NUM_PINS-1:0] pin_out, // Device level
  input wire logic [NUM_PINS-1:0] pin_oe, // Device drives
  input wire logic [NUM_PINS-1:0] pull_up, // Pull-ups
  input wire logic [NUM_PINS-1:0] pull_down, // Pull-downs
  input wire logic [NUM_PINS-1:0] ext_val, // Button level
  input wire logic [NUM_PINS-1:0] ext_en, // Button drives
  output logic [NUM_PINS-1:0] pin_level // Wire level
);
  // A floating pin shows the inverse of the device output level, not a guess
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else if (pull_up[i] || pull_down[i])
        pin_level[i] = pull_up[i];
      else
        pin_level[i] = ~pin_out[i];
    end
  end
endmodule
`default_nettype wire

// ---- tb/gpo_top_test.sv ----
// Testbench: register access, pin functions and interrupt latching
`timescale 1ns/10ps
`default_nettype none
module gpo_top_test
  import gpo_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, e, r;
  logic hreadyout, hresp, tris, irq;
  logic [2:0] pin_in, pin_out, pin_oe, pu, pd;
  logic [2:0] ext_val = 3'h0;
  logic [2:0] ext_en = 3'h7;
  logic in7 = 1'b0, in8 = 1'b0, lock = 1'b0, temp = 1'b1, micd = 1'b0, mics = 1'b0;
  logic rd_dp = 1'b0;
  logic [31:0] expq[$];
  int errors = 0, cmp_count = 0, cyc = 0, n;

  gpo_top uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gp_pin_in(pin_in), .gp_pin_out(pin_out),
    .gp_pin_oe(pin_oe), .pin_pull_up(pu), .pin_pull_down(pd), .gp_input_7(in7),
    .gp_input_8(in8), .lock_status(lock), .temp_ok_status(temp), .mic_detect_status(micd),
    .mic_short_status(mics), .audio_if_tristate(tris), .irq_out(irq));
  gpo_host_model host (.pin_out(pin_out), .pin_oe(pin_oe), .pull_up(pu), .pull_down(pd),
    .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_in));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A read only notes its expected word; the monitor compares it
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
    if (!w)
      expq.push_back(d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'b00};
    do @(posedge sys_clk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge sys_clk); while (!hreadyout);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] d);
    bus(1'b0, idx, d);
  endtask
  task automatic toggles(output int t);
    logic prev;
    t = 0;
    @(posedge sys_clk);
    #1;
    prev = pin_out[0];
    repeat (16) begin
      @(posedge sys_clk);
      #1;
      if (pin_out[0] !== prev)
        t++;
      prev = pin_out[0];
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
    if (rd_dp && hreadyout)
      check(hrdata, expq.pop_front(), "read data");
    if (hreadyout)
      rd_dp = hsel && htrans[1] && !hwrite;
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    r = $urandom(80801);
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(IDX_INTERRUPT_ENABLE_CONTROL, 32'h8000);
    rd(IDX_SOURCE_POLARITY_CONTROL, 32'h0800);
    rd(IDX_STATUS, 32'h0);
    rd(6'h3f, 32'h0);
    wr(IDX_CLOCK_PAD_CONTROL, 32'h0);
    // Code 6 floats the pin; code 7 drives the flag, low while all source enables are off
    for (int c = 2; c < 10; c++) begin
      @(posedge sys_clk);
      r = $urandom;
      lock <= r[0];
      temp <= r[1];
      micd <= r[2];
      mics <= r[3];
      e = c == 3 ? 32'h7 : c == 4 ? {29'h0, {3{r[0]}}} : c == 5 ? {29'h0, {3{r[1]}}} :
        c == 8 ? {29'h0, {3{r[2]}}} : c == 9 ? {29'h0, {3{r[3]}}} : 32'h0;
      wr(IDX_PIN_FUNCTION_SELECT, {20'h0, {3{c[3:0]}}});
      settle();
      check(32'(pin_oe), c == 6 ? 32'h0 : 32'h7, "pin enable");
      check(32'(pin_out), e, "pin level");
    end
    wr(IDX_PIN_FUNCTION_SELECT, 32'h111);
    wr(IDX_CLOCK_PAD_CONTROL, 32'h11);
    toggles(n);
    check(32'(n), 32'h8, "clock toggles");
    wr(IDX_CLOCK_PAD_CONTROL, 32'h01);
    toggles(n);
    check(32'(n), 32'h0, "stopped clock");
    // Pulls on while tristated; bits outside the writable mask read back 0
    wr(IDX_CLOCK_PAD_CONTROL, 32'hffff_ff20);
    settle();
    check(32'(pin_oe), 32'h0, "tristate");
    check(32'(tris), 32'h1, "tristate out");
    check(32'({pu, pd}), 32'h3f, "pulls");
    rd(IDX_CLOCK_PAD_CONTROL, 32'h7720);
    wr(IDX_CLOCK_PAD_CONTROL, 32'h0);
    wr(IDX_PIN_FUNCTION_SELECT, 32'h007);
    lock <= 1'b0;
    temp <= 1'b1;
    micd <= 1'b0;
    mics <= 1'b0;
    wr(IDX_STATUS, 32'hfff);
    wr(IDX_INTERRUPT_ENABLE_CONTROL, 32'h100);
    lock <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check(32'(irq), 32'h1, "irq raised");
    check(32'(pin_out[0]), 32'h1, "irq pin");
    @(posedge sys_clk);
    lock <= 1'b0;
    wr(IDX_STATUS, 32'h0);
    rd(IDX_STATUS, 32'h1100);
    wr(IDX_STATUS, 32'h100);
    #1;
    check(32'(irq), 32'h0, "irq cleared");
    @(posedge sys_clk);
    lock <= 1'b1;
    wr(IDX_STATUS, 32'h100);
    rd(IDX_STATUS, 32'h1100);
    wr(IDX_SOURCE_POLARITY_CONTROL, 32'h1800);
    #1;
    check(32'(irq), 32'h0, "irq inverted");
    settle();
    check(32'(pin_out[0]), 32'h0, "inverted pin");
    wr(IDX_SOURCE_POLARITY_CONTROL, 32'h0800);
    wr(IDX_INTERRUPT_ENABLE_CONTROL, 32'h0);
    rd(IDX_STATUS, 32'h0100);
    // Level detection: flip the lock polarity so a low lock level relatches
    wr(IDX_SOURCE_POLARITY_CONTROL, 32'h0900);
    wr(IDX_STATUS, 32'h100);
    rd(IDX_STATUS, 32'h0);
    lock <= 1'b0;
    wr(IDX_SOURCE_POLARITY_CONTROL, 32'h0800);
    rd(IDX_STATUS, 32'h0100);
    temp <= 1'b0;
    wr(IDX_INTERRUPT_ENABLE_CONTROL, 32'h800);
    rd(IDX_STATUS, 32'h1900);
    check(32'(irq), 32'h1, "temp irq");
    temp <= 1'b1;
    wr(IDX_PIN_FUNCTION_SELECT, 32'h0);
    wr(IDX_INTERRUPT_ENABLE_CONTROL, 32'hfdc);
    repeat (6) begin
      r = $urandom;
      {ext_val, in7, in8, lock, micd, mics} <= r[7:0];
      repeat (2) @(posedge sys_clk);
      wr(IDX_STATUS, 32'hfff);
      e = {21'h0, mics, micd, lock, in8, in7, 1'b0, ext_val, 2'b00};
      rd(IDX_STATUS, e | {19'h0, |e, 12'h0});
      check(32'(irq), 32'(|e), "random irq");
    end
    conclude();
  end
endmodule
`default_nettype wire
